// >>> rtl/capture_defines.svh
// Constants for the four-channel input capture block
// Notes on behaviour
// - Four independent capture channels, each timestamping edges on its own input.
// - Adjacent channel pairs cascade into one 32-bit capture in capture modes 001 to 101; modes 000, 110 and event mode 111 store nothing.
// - Each channel buffers up to four captured counter values first-in first-out.
// - Each channel owns a 16-bit counter clocked from up to six sources.
// - Counter runs synchronised or triggered, source picked from up to 21 inputs.
// - Halt-when-idle bit 13 set stops the channel while the processor idles.
// - Clock select 100 uses first timer clock; 101 and 110 are reserved.
// - Clock select 011 uses the fifth timer clock.
// - Capture mode 000 turns the channel off; no captures are taken, except on an odd channel cascaded to its even partner.
`ifndef CAPTURE_DEFINES_SVH
`define CAPTURE_DEFINES_SVH
`define CH_COUNT 4
`define OFS_CON1 2'h0
`define OFS_CON2 2'h1
`define OFS_BUF 2'h2
`define OFS_CNT 2'h3
`define ADDR_STAT 5'h10
`define ADDR_MASK 5'h11
`define CON1_RESET 16'h0000
`define CON2_RESET 16'h0000
`define STAT_RESET 8'h00
`define MASK_RESET 8'h00
`define CON1_WMASK 16'h3C67
`define CON2_WMASK 16'h019F
`define TSEL_T5 3'h3
`define TSEL_T1 3'h4
`define TSEL_PCLK 3'h7
`define SYNC_SRC_COUNT 5'h15
`define PRESC4_LAST 4'h3
`define PRESC16_LAST 4'hF
`define FIFO_DEPTH 3'h4
`define CNT_TOP 16'hFFFF
`endif

// >>> rtl/capture_fifo_mem.sv
// Four-word storage for one capture FIFO with registered read data
`timescale 1ns/1ps
`default_nettype none
module capture_fifo_mem (
  input  wire logic        mclk,
  input  wire logic        rstn,
  input  wire logic        wrEn,
  input  wire logic [1:0]  wrAddr,
  input  wire logic [15:0] wrData,
  input  wire logic        rdEn,
  input  wire logic [1:0]  rdAddr,
  output logic      [15:0] rdData
);
  logic [15:0] mem [4];

  always_ff @(posedge mclk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rdData <= 16'h0000;
    end else if (rdEn) begin
      rdData <= mem[rdAddr];
    end
  end
endmodule // capture_fifo_mem
`default_nettype wire

// >>> rtl/capture_pkg.sv
// Types shared by the input capture block
package capture_pkg;
  typedef enum logic [2:0] {
    MODE_OFF    = 3'h0,
    MODE_BOTH   = 3'h1,
    MODE_FALL   = 3'h2,
    MODE_RISE   = 3'h3,
    MODE_RISE4  = 3'h4,
    MODE_RISE16 = 3'h5,
    MODE_RSVD   = 3'h6,
    MODE_EVENT  = 3'h7
  } capture_mode_t;
  typedef struct packed {
    logic [1:0]    unused15;
    logic          haltWhenIdle;
    logic [2:0]    counterClockSelect;
    logic [2:0]    unused9;
    logic [1:0]    captureDecimation;
    logic          overflow;
    logic          bufferNotEmpty;
    capture_mode_t captureModeField;
  } con1_t;
  typedef struct packed {
    logic [6:0] unused15;
    logic       cascade;
    logic       triggerMode;
    logic [1:0] unused6;
    logic [4:0] syncSelect;
  } con2_t;
endpackage

// >>> rtl/input_capture_channel.sv
// Four-channel input capture with counters, FIFOs, cascade and interrupt
`timescale 1ns/1ps
`default_nettype none
`include "capture_defines.svh"
module input_capture_channel
  import capture_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rstn,
  input  wire logic [4:0]  busAddr,
  input  wire logic [15:0] busWdata,
  input  wire logic        busWr,
  input  wire logic        busRd,
  output logic      [15:0] busRdata,
  input  wire logic [3:0]  captureChannel,
  input  wire logic        cpuIdle,
  input  wire logic        firstTimerClock,
  input  wire logic [2:0]  midTimerClock,
  input  wire logic        fifthTimerClock,
  input  wire logic [20:0] syncSource,
  output logic             irq
);
  // ==========================================================
  // Declarations
  con1_t       con1   [4];
  con2_t       con2   [4];
  logic [15:0] con1Rd [4];
  logic [15:0] cnt    [4];
  logic [15:0] memQ   [4];
  logic [1:0]  wrPtr  [4];
  logic [1:0]  rdPtr  [4];
  logic [2:0]  fill   [4];
  logic [3:0]  presc  [4];
  capture_mode_t effMode [4];
  logic [3:0]  ovf;
  logic [3:0]  armed;
  logic [3:0]  run;
  logic [3:0]  selTick;
  logic [3:0]  carry;
  logic [3:0]  cntTick;
  logic [3:0]  edgeOwn;
  logic [3:0]  capEvt;
  logic [3:0]  push;
  logic [3:0]  pop;
  logic [3:0]  full;
  logic [3:0]  ovfEvt;
  logic [3:0]  wrCon1;
  logic [3:0]  wrCon2;
  logic [3:0]  hitSync;
  logic [3:0]  ownOn;
  logic [3:0]  modeOn;
  logic [3:0]  cascOdd;
  logic [15:0] rdReg;
  logic [15:0] rdNext;
  logic [7:0]  stat;
  logic [7:0]  mask;
  logic [7:0]  statClr;
  logic        bufRdQ;
  logic [1:0]  bufCh;
  wire         inCh  = ~busAddr[4];
  wire  [1:0]  chSel = busAddr[3:2];
  wire  [1:0]  ofs   = busAddr[1:0];
  wire  [3:0]  tickSet = {fifthTimerClock, midTimerClock};

  // ==========================================================
  // Per-channel logic
  for (genvar i = 0; i < `CH_COUNT; i++) begin : g_ch
    localparam int E = i & 2;
    localparam bit ODD = (i % 2) == 1;
    logic [2:0]    pinSync;
    logic          pinLvl;
    logic          agree;
    logic          rise;
    logic          fall;
    logic          edgeHit;
    logic          prescMode;
    logic          lastPresc;
    logic [20:0]   srcShift;
    capture_mode_t mode;

    assign mode = con1[i].captureModeField;
    assign wrCon1[i] = busWr && inCh && (chSel == i) && (ofs == `OFS_CON1);
    assign wrCon2[i] = busWr && inCh && (chSel == i) && (ofs == `OFS_CON2);

    // Control registers
    always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
        con1[i] <= `CON1_RESET;
        con2[i] <= `CON2_RESET;
      end else begin
        if (wrCon1[i]) begin
          con1[i] <= busWdata & `CON1_WMASK;
        end
        if (wrCon2[i]) begin
          con2[i] <= busWdata & `CON2_WMASK;
        end
      end
    end
    assign con1Rd[i] = con1[i] | {11'h000, ovf[i], (fill[i] != 3'h0), 3'h0};

    // Pin synchroniser, change taken once second and third stages agree
    always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
        pinSync <= 3'h0;
        pinLvl  <= 1'b0;
      end else begin
        pinSync <= {pinSync[1:0], captureChannel[i]};
        pinLvl  <= agree ? pinSync[2] : pinLvl;
      end
    end
    assign agree = pinSync[1] == pinSync[2];
    assign rise  = agree && pinSync[2] && !pinLvl;
    assign fall  = agree && !pinSync[2] && pinLvl;

    // Counter clock selection
    assign selTick[i] =
      (con1[i].counterClockSelect == `TSEL_PCLK) ? 1'b1 :
      (con1[i].counterClockSelect == `TSEL_T1)   ? firstTimerClock :
      (con1[i].counterClockSelect <= `TSEL_T5)   ?
        tickSet[con1[i].counterClockSelect[1:0]] : 1'b0;
    assign carry[i]   = selTick[i] && (cnt[i] == `CNT_TOP);
    assign cascOdd[i] = ODD && con2[E].cascade;
    assign cntTick[i] = cascOdd[i] ? carry[E] : selTick[i];
    assign effMode[i] = cascOdd[i] ? con1[E].captureModeField : mode;
    assign ownOn[i]   = (mode != MODE_OFF) && (mode != MODE_RSVD);
    assign modeOn[i]  = cascOdd[i] ? ownOn[E] : ownOn[i];
    assign run[i]     = !(con1[i].haltWhenIdle && cpuIdle);

    // Sync and trigger source selection
    assign srcShift   = syncSource >> (con2[i].syncSelect - 5'h01);
    assign hitSync[i] = (con2[i].syncSelect != 5'h00) &&
                        (con2[i].syncSelect <= `SYNC_SRC_COUNT) && srcShift[0];

    // Trigger arm and the 16-bit counter
    always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
        armed[i] <= 1'b0;
      end else if (!modeOn[i] || !con2[i].triggerMode) begin
        armed[i] <= 1'b0;
      end else if (run[i] && hitSync[i]) begin
        armed[i] <= 1'b1;
      end
    end

    always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
        cnt[i] <= 16'h0000;
      end else if (!modeOn[i]) begin
        cnt[i] <= 16'h0000;
      end else if (run[i] && hitSync[i] && !con2[i].triggerMode) begin
        cnt[i] <= 16'h0000;
      end else if (run[i] && cntTick[i] && (armed[i] || !con2[i].triggerMode)) begin
        cnt[i] <= cnt[i] + 16'h0001;
      end
    end

    // Edge qualification and prescaler
    assign prescMode = (mode == MODE_RISE4) || (mode == MODE_RISE16);
    assign lastPresc = presc[i] == ((mode == MODE_RISE16) ? `PRESC16_LAST : `PRESC4_LAST);
    assign edgeHit = (mode == MODE_BOTH) ? (rise || fall) :
                     (mode == MODE_FALL) ? fall : (ownOn[i] && rise);
    always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
        presc[i] <= 4'h0;
      end else if (!prescMode) begin
        presc[i] <= 4'h0;
      end else if (rise && run[i]) begin
        presc[i] <= lastPresc ? 4'h0 : presc[i] + 4'h1;
      end
    end
    assign edgeOwn[i] = edgeHit && run[i] && (!prescMode || lastPresc);
    assign capEvt[i]  = cascOdd[i] ? edgeOwn[E] : edgeOwn[i];
    assign full[i]    = fill[i] == `FIFO_DEPTH;
    assign push[i]    = capEvt[i] && (effMode[i] != MODE_EVENT) && !full[i];
    assign ovfEvt[i]  = capEvt[i] && (effMode[i] != MODE_EVENT) && full[i];
    assign pop[i]     = busRd && inCh && (chSel == i) && (ofs == `OFS_BUF) &&
                        (fill[i] != 3'h0);

    // FIFO pointers, fill level and overflow flag
    always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
        wrPtr[i] <= 2'h0;
        rdPtr[i] <= 2'h0;
        fill[i]  <= 3'h0;
      end else if (!modeOn[i]) begin
        wrPtr[i] <= 2'h0;
        rdPtr[i] <= 2'h0;
        fill[i]  <= 3'h0;
      end else begin
        wrPtr[i] <= wrPtr[i] + {1'b0, push[i]};
        rdPtr[i] <= rdPtr[i] + {1'b0, pop[i]};
        fill[i]  <= fill[i] + {2'h0, push[i]} - {2'h0, pop[i]};
      end
    end

    always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
        ovf[i] <= 1'b0;
      end else if (!modeOn[i]) begin
        ovf[i] <= 1'b0;
      end else if (ovfEvt[i]) begin
        ovf[i] <= 1'b1;
      end else if (pop[i]) begin
        ovf[i] <= 1'b0;
      end
    end

    capture_fifo_mem u_mem (
      .mclk   (mclk),
      .rstn   (rstn),
      .wrEn   (push[i]),
      .wrAddr (wrPtr[i]),
      .wrData (cnt[i]),
      .rdEn   (pop[i]),
      .rdAddr (rdPtr[i]),
      .rdData (memQ[i])
    );
  end

  // ==========================================================
  // Register read path
  assign rdNext = !inCh ?
                    ((busAddr == `ADDR_STAT) ? {8'h00, stat} :
                     (busAddr == `ADDR_MASK) ? {8'h00, mask} : 16'h0000) :
                  (ofs == `OFS_CON1) ? con1Rd[chSel] :
                  (ofs == `OFS_CON2) ? con2[chSel] :
                  (ofs == `OFS_CNT)  ? cnt[chSel] : 16'h0000;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rdReg  <= 16'h0000;
      bufRdQ <= 1'b0;
      bufCh  <= 2'h0;
    end else begin
      rdReg  <= busRd ? rdNext : 16'h0000;
      bufRdQ <= busRd && inCh && (ofs == `OFS_BUF);
      bufCh  <= chSel;
    end
  end
  assign busRdata = bufRdQ ? memQ[bufCh] : rdReg;

  // ==========================================================
  // Interrupt status, mask and output
  assign statClr = (busWr && (busAddr == `ADDR_STAT)) ? busWdata[7:0] : 8'h00;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      stat <= `STAT_RESET;
      mask <= `MASK_RESET;
      irq  <= 1'b0;
    end else begin
      stat <= (stat & ~statClr) | {ovfEvt, capEvt};
      if (busWr && (busAddr == `ADDR_MASK)) begin
        mask <= busWdata[7:0];
      end
      irq <= |(stat & mask);
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  property p_fifo_bound;
    fill[0] <= `FIFO_DEPTH && fill[3] <= `FIFO_DEPTH;
  endproperty
  a_fifo_bound: assert property (p_fifo_bound) else $error("fifo overfilled");

  property p_push_grows;
    push[1] && !pop[1] && modeOn[1] |=> fill[1] == $past(fill[1]) + 3'h1;
  endproperty
  a_push_grows: assert property (p_push_grows) else $error("push lost");

  property p_off_idle;
    !modeOn[0] |-> !push[0] ##1 fill[0] == 3'h0;
  endproperty
  a_off_idle: assert property (p_off_idle) else $error("capture while off");

  property p_halt_holds;
    con1[2].haltWhenIdle && cpuIdle && !busWr |=> $stable(cnt[2]);
  endproperty
  a_halt_holds: assert property (p_halt_holds) else $error("counter ran in idle");

  property p_pclk_counts;
    con1[3].counterClockSelect == `TSEL_PCLK && run[3] && modeOn[3] && cnt[3] != `CNT_TOP
      && !cascOdd[3] && !con2[3].triggerMode && con2[3].syncSelect == 5'h00 && !busWr
      |=> cnt[3] == $past(cnt[3]) + 16'h0001;
  endproperty
  a_pclk_counts: assert property (p_pclk_counts) else $error("no count");

  property p_t5_gate;
    con1[2].counterClockSelect == `TSEL_T5 && !fifthTimerClock && !hitSync[2]
      && modeOn[2] && !busWr |=> $stable(cnt[2]);
  endproperty
  a_t5_gate: assert property (p_t5_gate) else $error("counted without tick");

  property p_rsvd_sel;
    con1[1].counterClockSelect inside {3'h5, 3'h6} |-> !selTick[1];
  endproperty
  a_rsvd_sel: assert property (p_rsvd_sel) else $error("reserved select ticked");

  property p_cascade;
    con2[0].cascade && push[0] && !full[1] |-> push[1];
  endproperty
  a_cascade: assert property (p_cascade) else $error("cascade half missed");

  property p_sync_reset;
    hitSync[0] && !con2[0].triggerMode && run[0] && modeOn[0] && !busWr |=> cnt[0] == 16'h0000;
  endproperty
  a_sync_reset: assert property (p_sync_reset) else $error("sync missed");

  property p_cnt_step;
    modeOn[2] && !busWr |=> cnt[2] == $past(cnt[2]) || cnt[2] == 16'h0000
      || cnt[2] == $past(cnt[2]) + 16'h0001;
  endproperty
  a_cnt_step: assert property (p_cnt_step) else $error("counter jumped");

  property p_irq_level;
    (|(stat & mask)) |=> irq;
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("irq not raised");

  c_push:     cover property (push[0] ##[1:20] pop[0]);
  c_overflow: cover property (ovfEvt[2]);
  c_cascade:  cover property (con2[0].cascade && push[1]);
  c_irq:      cover property ($rose(irq));
endmodule // input_capture_channel
`default_nettype wire

// >>> tb/capture_signal_source.sv
// Model of the external signals whose edges the capture channels time
`timescale 1ns/1ps
`default_nettype none
module capture_signal_source (
  input  wire logic       mclk,
  output logic      [3:0] captureChannel
);
  initial captureChannel = 4'h0;
  // =====================================
  // One pulse, long enough to be seen
  task automatic pulse(input int ch);
    @(posedge mclk);
    captureChannel[ch] <= 1'b1;
    repeat (3) @(posedge mclk);
    captureChannel[ch] <= 1'b0;
    repeat (3) @(posedge mclk);
  endtask
endmodule // capture_signal_source
`default_nettype wire

// >>> tb/test_input_capture_channel.sv
// Self-checking testbench for the input capture block
`timescale 1ns/1ps
`default_nettype none
module test_input_capture_channel;
  logic        mclk;
  logic        rstn;
  logic [4:0]  busAddr;
  logic [15:0] busWdata;
  logic        busWr;
  logic        busRd;
  logic [15:0] busRdata;
  logic [3:0]  captureChannel;
  logic        cpuIdle;
  logic        firstTimerClock;
  logic [2:0]  midTimerClock;
  logic        fifthTimerClock;
  logic [20:0] syncSource;
  logic        irq;
  logic [15:0] d;
  logic [15:0] c0;
  int          fails;
  int          comparisons;

  input_capture_channel i_dut (
    .mclk(mclk), .rstn(rstn), .busAddr(busAddr), .busWdata(busWdata),
    .busWr(busWr), .busRd(busRd), .busRdata(busRdata),
    .captureChannel(captureChannel), .cpuIdle(cpuIdle),
    .firstTimerClock(firstTimerClock), .midTimerClock(midTimerClock),
    .fifthTimerClock(fifthTimerClock), .syncSource(syncSource), .irq(irq)
  );
  capture_signal_source i_src (.mclk(mclk), .captureChannel(captureChannel));

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  // =====================================
  // Bus and stimulus tasks
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] v);
    @(posedge mclk);
    busWr    <= 1'b1;
    busAddr  <= a;
    busWdata <= v;
    @(posedge mclk);
    busWr <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a);
    @(posedge mclk);
    busRd   <= 1'b1;
    busAddr <= a;
    @(posedge mclk);
    busRd <= 1'b0;
    #1 d = busRdata;
  endtask
  task automatic ticks(input int n, input logic fifth);
    repeat (n) begin
      @(posedge mclk);
      firstTimerClock <= !fifth;
      fifthTimerClock <= fifth;
      @(posedge mclk);
      firstTimerClock <= 1'b0;
      fifthTimerClock <= 1'b0;
    end
  endtask
  task automatic cap(input int ch);
    i_src.pulse(ch);
    repeat (6) @(posedge mclk);
  endtask
  task automatic stop_test;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    #2000000;
    fails++;
    stop_test();
  end
  // =====================================
  // Main sequence
  initial begin
    rstn = 1'b0;
    busAddr = 5'h00;
    busWdata = 16'h0000;
    busWr = 1'b0;
    busRd = 1'b0;
    cpuIdle = 1'b0;
    firstTimerClock = 1'b0;
    midTimerClock = 3'h0;
    fifthTimerClock = 1'b0;
    syncSource = 21'h000000;
    repeat (4) @(posedge mclk);
    rstn <= 1'b1;
    rd(5'h00);
    check(d, 16'h0000);
    rd(5'h10);
    check(d, 16'h0000);
    wr(5'h14, 16'hFFFF);
    rd(5'h14);
    check(d, 16'h0000);
    // Capture on first timer clock, interrupt raise and clear
    wr(5'h11, 16'h0001);
    wr(5'h00, 16'h1003);
    ticks(5, 1'b0);
    cap(0);
    rd(5'h10);
    check(d, 16'h0001);
    check({15'h0000, irq}, 16'h0001);
    rd(5'h02);
    check(d, 16'h0005);
    wr(5'h10, 16'h0001);
    repeat (2) @(posedge mclk);
    check({15'h0000, irq}, 16'h0000);
    // Five events into a four-deep buffer
    repeat (5) begin
      ticks(1, 1'b0);
      cap(0);
    end
    rd(5'h00);
    check(d, 16'h101B);
    rd(5'h10);
    check(d, 16'h0011);
    for (int i = 6; i < 10; i++) begin
      rd(5'h02);
      check(d, 16'(i));
    end
    rd(5'h00);
    check(d, 16'h1003);
    wr(5'h10, 16'h0011);
    // Sync source resets the counter
    wr(5'h01, 16'h0001);
    ticks(2, 1'b0);
    @(posedge mclk);
    syncSource[0] <= 1'b1;
    @(posedge mclk);
    syncSource[0] <= 1'b0;
    rd(5'h03);
    check(d, 16'h0000);
    wr(5'h01, 16'h0000);
    // Halt while idle
    ticks(3, 1'b0);
    wr(5'h00, 16'h3003);
    cpuIdle <= 1'b1;
    rd(5'h03);
    c0 = d;
    ticks(3, 1'b0);
    rd(5'h03);
    check(d, c0);
    wr(5'h00, 16'h1003);
    ticks(2, 1'b0);
    rd(5'h03);
    check(d, c0 + 16'h0002);
    cpuIdle <= 1'b0;
    // Mode off takes nothing
    wr(5'h00, 16'h1000);
    cap(0);
    rd(5'h00);
    check(d, 16'h1000);
    rd(5'h03);
    check(d, 16'h0000);
    // Fifth timer clock on channel two
    wr(5'h08, 16'h0C03);
    ticks(4, 1'b1);
    cap(2);
    rd(5'h0A);
    check(d, 16'h0004);
    rd(5'h10);
    check(d, 16'h0004);
    // Event mode flags without storing; prescaler takes every fourth rise
    wr(5'h10, 16'h0004);
    wr(5'h08, 16'h0C07);
    cap(2);
    rd(5'h10);
    check(d, 16'h0004);
    rd(5'h08);
    check(d, 16'h0C07);
    wr(5'h08, 16'h0C04);
    repeat (4) begin
      ticks(1, 1'b1);
      cap(2);
    end
    rd(5'h0A);
    check(d, 16'h0008);
    rd(5'h08);
    check(d, 16'h0C04);
    // Peripheral clock counts every cycle
    wr(5'h0C, 16'h1C03);
    rd(5'h0F);
    c0 = d;
    rd(5'h0F);
    check(d - c0, 16'h0002);
    // Cascaded pair pushes into the odd channel's buffer too; only channel one's buffer is checked
    wr(5'h01, 16'h0100);
    wr(5'h00, 16'h1003);
    cap(0);
    rd(5'h04);
    check(d & 16'h0008, 16'h0008);
    rd(5'h06);
    check(d, 16'h0000);
    stop_test();
  end
endmodule // test_input_capture_channel
`default_nettype wire
